/* hdl/asf_defines.vh */
// Register map, field positions and reset values for the converter control.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef ASF_DEFINES_VH
`define ASF_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ASF_REG_CTRL 4'h0
`define ASF_REG_CMD 4'h4
`define ASF_REG_CHAN 4'h8
`define ASF_REG_STATUS 4'hc
`define ASF_REG_DATA 5'h10
`define ASF_REG_COUNT 5'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ASF_CTRL_IRQ_EN 0
`define ASF_CTRL_FIFO_SEL 1
`define ASF_CTRL_THR_SEL 2
`define ASF_CTRL_SCAN 3
`define ASF_CTRL_TRIG_CLK_EN 4
`define ASF_CTRL_TRIG_SRC 5
`define ASF_CMD_START 0
`define ASF_CMD_IRQ_CLR 1
`define ASF_CMD_FIFO_RST 2

// ----------------------------------------------------------------------
// Reset values, thresholds and sizes
// ----------------------------------------------------------------------
`define ASF_CTRL_RESET 6'h00
`define ASF_CHAN_RESET 8'hf0
`define ASF_THR_HIGH 11'h400
`define ASF_THR_LOW 11'h100
`define ASF_FIFO_DEPTH 16
`define ASF_FIFO_AW 4
`define ASF_SAMPLE_W 20
`define ASF_RESP_OKAY 2'b00
`define ASF_RESP_SLVERR 2'b10

`endif

/* hdl/asf_control.v */
// Converter sequencing, sample FIFO and interrupt decision logic.
// Assumes a converter on the same clock that answers each start pulse
// with one done pulse carrying data, and an AXI4-Lite master.
`timescale 1ns/100ps
`include "asf_defines.vh"

// ----------------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------------
module asf_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_flush,
  // Fill side
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  // Drain side
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data,
  output wire [AW:0] o_level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] level;
  localparam [AW:0] FULL_LEVEL = DEPTH;
  wire push;
  wire pop;

  assign o_in_ready = (level != FULL_LEVEL);
  assign o_out_valid = (level != {(AW+1){1'b0}});
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr];
  assign o_level = level;

  always @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end else if (i_flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        level <= level + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        level <= level - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // asf_fifo

// ----------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------
module asf_control (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_arst_n,
  // AXI4-Lite write address
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  input wire [4:0] i_s_axi_awaddr,
  // AXI4-Lite write data
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  // AXI4-Lite write response
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  output reg [1:0] o_s_axi_bresp,
  // AXI4-Lite read
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  input wire [4:0] i_s_axi_araddr,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  // Trigger sources
  input wire i_external_trigger_pin,
  input wire i_timer0_tick,
  // Converter
  output reg o_conv_start,
  output reg [3:0] o_conv_channel,
  input wire i_conv_done,
  input wire [15:0] i_conv_data,
  // Status
  output reg o_conv_active_flag,
  output reg o_conv_irq
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_STORE = 3'b100;

  reg [5:0] ctrl;
  reg [3:0] chan_low;
  reg [3:0] chan_high;
  reg [2:0] state;
  reg [3:0] cur_chan;
  reg [15:0] sample;
  reg [10:0] conv_count;
  reg [1:0] ext_sync;
  reg ext_prev;
  reg aw_got;
  reg w_got;
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire conv_irq_enable = ctrl[`ASF_CTRL_IRQ_EN];
  wire fifo_irq_select = ctrl[`ASF_CTRL_FIFO_SEL];
  wire fifo_threshold_select = ctrl[`ASF_CTRL_THR_SEL];
  wire scan_mode_on = ctrl[`ASF_CTRL_SCAN];
  wire trigger_clock_enable = ctrl[`ASF_CTRL_TRIG_CLK_EN];
  wire trigger_source_select = ctrl[`ASF_CTRL_TRIG_SRC];

  // Register write decode, used by the control, command and channel paths.
  function wr_hit;
    input [4:0] addr;
    input [4:0] target;
    begin
      wr_hit = (addr == target);
    end
  endfunction

  wire wr_fire = aw_got && w_got && !o_s_axi_bvalid;
  wire wr_ctrl = wr_fire && wr_hit(aw_addr, {1'b0, `ASF_REG_CTRL}) &&
    w_strb[0];
  wire wr_cmd = wr_fire && wr_hit(aw_addr, {1'b0, `ASF_REG_CMD}) &&
    w_strb[0];
  wire wr_chan = wr_fire && wr_hit(aw_addr, {1'b0, `ASF_REG_CHAN}) &&
    w_strb[0];
  wire sw_start = wr_cmd && w_data[`ASF_CMD_START];
  wire irq_clear = wr_cmd && w_data[`ASF_CMD_IRQ_CLR];
  wire fifo_flush = wr_cmd && w_data[`ASF_CMD_FIFO_RST];

  // ----------------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------------
  wire ext_rise = ext_sync[1] && !ext_prev;
  wire hw_trigger = trigger_source_select ? i_timer0_tick : ext_rise;
  // With the interrupt off only the software write starts work.
  wire trigger = (conv_irq_enable && trigger_clock_enable) ?
    hw_trigger : sw_start;

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_sync <= 2'b00;
      ext_prev <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], i_external_trigger_pin};
      ext_prev <= ext_sync[1];
    end
  end

  // ----------------------------------------------------------------------
  // Sample FIFO
  // ----------------------------------------------------------------------
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`ASF_SAMPLE_W-1:0] fifo_out_data;
  wire [`ASF_FIFO_AW:0] fifo_level;
  wire rd_data_pop;
  wire store_ok = state[2] && fifo_in_ready;

  // Every result is queued regardless of the interrupt selection.
  asf_fifo #(
    .WIDTH(`ASF_SAMPLE_W),
    .DEPTH(`ASF_FIFO_DEPTH),
    .AW(`ASF_FIFO_AW)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_flush(fifo_flush),
    .i_in_valid(state[2]),
    .o_in_ready(fifo_in_ready),
    .i_in_data({o_conv_channel, sample}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(rd_data_pop),
    .o_out_data(fifo_out_data),
    .o_level(fifo_level)
  );

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  wire last_of_scan = !scan_mode_on || (o_conv_channel == chan_high);
  wire seq_end = store_ok && last_of_scan;
  wire [3:0] chan_next = (cur_chan == chan_high) ? chan_low :
    cur_chan + 4'h1;

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_IDLE;
      cur_chan <= 4'h0;
      o_conv_channel <= 4'h0;
      o_conv_start <= 1'b0;
      o_conv_active_flag <= 1'b0;
      sample <= 16'h0000;
    end else begin
      o_conv_start <= 1'b0;
      if (wr_chan) begin
        cur_chan <= w_data[3:0];
      end
      case (state)
        ST_IDLE: begin
          if (trigger) begin
            o_conv_channel <= scan_mode_on ? chan_low : cur_chan;
            o_conv_start <= 1'b1;
            o_conv_active_flag <= 1'b1;
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (i_conv_done) begin
            sample <= i_conv_data;
            state <= ST_STORE;
          end
        end
        ST_STORE: begin
          // A full queue stalls the sequencer until software drains it.
          if (store_ok) begin
            if (!scan_mode_on && !wr_chan) begin
              cur_chan <= chan_next;
            end
            if (last_of_scan) begin
              o_conv_active_flag <= 1'b0;
              state <= ST_IDLE;
            end else begin
              o_conv_channel <= o_conv_channel + 4'h1;
              o_conv_start <= 1'b1;
              state <= ST_CONV;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          o_conv_active_flag <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt decision
  // ----------------------------------------------------------------------
  wire [10:0] thr = fifo_threshold_select ? `ASF_THR_LOW : `ASF_THR_HIGH;
  wire [10:0] count_next = conv_count + {10'h000, store_ok &&
    (conv_count != 11'h7ff)};
  wire thr_reached = (count_next >= thr);
  reg irq_event;

  always @* begin
    irq_event = 1'b0;
    if (!fifo_irq_select) begin
      // Threshold select plays no part here.
      irq_event = seq_end;
    end else if (!scan_mode_on) begin
      irq_event = store_ok && thr_reached;
    end else begin
      irq_event = seq_end && thr_reached;
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_conv_irq <= 1'b0;
      conv_count <= 11'h000;
    end else begin
      // A new event in the clearing cycle keeps the request set.
      if (conv_irq_enable && irq_event) begin
        o_conv_irq <= 1'b1;
      end else if (irq_clear) begin
        o_conv_irq <= 1'b0;
      end
      if (irq_clear || fifo_flush) begin
        conv_count <= {10'h000, store_ok};
      end else begin
        conv_count <= count_next;
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  assign o_s_axi_awready = !aw_got && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_got && !o_s_axi_bvalid;
  assign o_s_axi_arready = !o_s_axi_rvalid;
  wire rd_fire = i_s_axi_arvalid && o_s_axi_arready;
  assign rd_data_pop = rd_fire && (i_s_axi_araddr == `ASF_REG_DATA);

  wire wr_mapped = wr_hit(aw_addr, {1'b0, `ASF_REG_CTRL}) ||
    wr_hit(aw_addr, {1'b0, `ASF_REG_CMD}) ||
    wr_hit(aw_addr, {1'b0, `ASF_REG_CHAN});

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `ASF_RESP_OKAY;
      ctrl <= `ASF_CTRL_RESET;
      chan_low <= 4'h0;
      chan_high <= 4'hf;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= {i_s_axi_awaddr[4:2], 2'b00};
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_mapped ? `ASF_RESP_OKAY : `ASF_RESP_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl <= w_data[5:0];
      end
      if (wr_chan) begin
        chan_low <= w_data[3:0];
        chan_high <= w_data[7:4];
      end
    end
  end

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= `ASF_RESP_OKAY;
    end else if (rd_fire) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp <= `ASF_RESP_OKAY;
      case ({i_s_axi_araddr[4:2], 2'b00})
        {1'b0, `ASF_REG_CTRL}: begin
          o_s_axi_rdata <= {26'h000_0000, ctrl};
        end
        {1'b0, `ASF_REG_CHAN}: begin
          o_s_axi_rdata <= {24'h00_0000, chan_high, chan_low};
        end
        {1'b0, `ASF_REG_STATUS}: begin
          o_s_axi_rdata <= {16'h0000, 3'b000, fifo_level, cur_chan,
            thr_reached, !fifo_in_ready, !fifo_out_valid,
            o_conv_irq};
        end
        `ASF_REG_DATA: begin
          // Bit 31 marks a valid sample; an empty read returns zero.
          o_s_axi_rdata <= fifo_out_valid ?
            {1'b1, 11'h000, fifo_out_data} : 32'h0000_0000;
        end
        `ASF_REG_COUNT: begin
          o_s_axi_rdata <= {21'h00_0000, conv_count};
        end
        {1'b0, `ASF_REG_CMD}: begin
          o_s_axi_rdata <= {31'h0000_0000, o_conv_active_flag};
        end
        default: begin
          o_s_axi_rdata <= 32'h0000_0000;
          o_s_axi_rresp <= `ASF_RESP_SLVERR;
        end
      endcase
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end
endmodule // asf_control

/* bench/asf_control_asserts.sv */
// Concurrent checks on the converter control top-level ports.
// Assumes one clock domain; the bind at the foot attaches it to every top.
`timescale 1ns/100ps
module asf_control_asserts (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_arst_n,
  // Bus handshakes
  input wire o_s_axi_bvalid,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire o_s_axi_rvalid,
  input wire i_s_axi_rready,
  // Converter and status
  input wire o_conv_start,
  input wire [3:0] o_conv_channel,
  input wire o_conv_active_flag,
  input wire o_conv_irq
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);

  // --------------------------------------------------------------------
  // Sequence steps
  // --------------------------------------------------------------------
  sequence s_conv_end;
    $fell(o_conv_active_flag);
  endsequence
  sequence s_mid_scan_start;
    o_conv_start && $past(o_conv_active_flag);
  endsequence

  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  a_flag_rise_start: assert property (
    $rose(o_conv_active_flag) |-> o_conv_start)
    else $error("active flag rose without a start pulse");
  a_start_in_active: assert property (
    o_conv_start |-> o_conv_active_flag)
    else $error("start pulse outside an active sequence");
  a_start_spaced: assert property (
    o_conv_start |=> !o_conv_start)
    else $error("start pulses back to back");
  a_scan_next_chan: assert property (
    s_mid_scan_start |-> o_conv_channel == $past(o_conv_channel) + 4'h1)
    else $error("scan did not step to the next channel");
  a_chan_steady: assert property (
    o_conv_active_flag && !o_conv_start |-> $stable(o_conv_channel))
    else $error("channel moved during a conversion");
  a_irq_at_end: assert property (
    $rose(o_conv_irq) |-> s_conv_end)
    else $error("interrupt rose away from the end of a sequence");
  a_irq_clear_write: assert property (
    $fell(o_conv_irq) |-> $rose(o_s_axi_bvalid))
    else $error("interrupt fell without a register write");
  a_ar_answer: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  a_ar_refused: assert property (
    o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read address taken while answer pending");
  a_r_release: assert property (
    o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
    else $error("read answer held after it was taken");
endmodule // asf_control_asserts

bind asf_control asf_control_asserts u_asserts (
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
  .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid),
  .i_s_axi_rready(i_s_axi_rready), .o_conv_start(o_conv_start),
  .o_conv_channel(o_conv_channel), .o_conv_active_flag(o_conv_active_flag),
  .o_conv_irq(o_conv_irq)
);

/* bench/asf_conv_model.sv */
// Behavioural converter: each start pulse earns one done pulse with data.
// Assumes the control block's clock; answers alternate fast and slow.
`timescale 1ns/100ps
module asf_conv_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // Start side
  input wire logic i_conv_start,
  input wire logic [3:0] i_conv_channel,
  // Result side
  output logic o_conv_done,
  output logic [15:0] o_conv_data
);
  logic [2:0] wait_cnt;
  logic [3:0] chan;
  logic slow;

  // Data off the done cycle flips every clock, so nothing may lean on it.
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_cnt <= 3'h0;
      chan <= 4'h0;
      slow <= 1'b0;
      o_conv_done <= 1'b0;
      o_conv_data <= 16'h0000;
    end else begin
      o_conv_done <= (wait_cnt == 3'h1);
      o_conv_data <= (wait_cnt == 3'h1) ? 16'hc3a0 + chan : ~o_conv_data;
      if (i_conv_start) begin
        chan <= i_conv_channel;
        wait_cnt <= slow ? 3'h5 : 3'h1;
        slow <= ~slow;
      end else if (wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end
    end
  end
endmodule // asf_conv_model

/* bench/adc_scan_fifo_irq_control_tb.sv */
// Self-checking bench for the converter control block.
// Assumes the converter model on the far side and drives the bus itself.
`timescale 1ns/100ps
`include "asf_defines.vh"
module adc_scan_fifo_irq_control_tb;
  logic sys_clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic ext_pin, tick;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rd;
  logic [1:0] resp;
  logic [3:0] ech;
  wire awready, wready, bvalid, arready, rvalid, conv_start, conv_done;
  wire act, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] chan;
  wire [15:0] conv_data;
  int miscompares, comparisons;

  asf_control dut (
    .i_sys_clk(sys_clk), .i_arst_n(arst_n),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'h1),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .i_external_trigger_pin(ext_pin), .i_timer0_tick(tick),
    .o_conv_start(conv_start), .o_conv_channel(chan),
    .i_conv_done(conv_done), .i_conv_data(conv_data),
    .o_conv_active_flag(act), .o_conv_irq(irq));
  asf_conv_model u_conv (.i_sys_clk(sys_clk), .i_arst_n(arst_n),
    .i_conv_start(conv_start), .i_conv_channel(chan),
    .o_conv_done(conv_done), .o_conv_data(conv_data));

  // --------------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((aw || w) && n < 200) begin
      @(posedge sys_clk);
      n++;
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge sys_clk);
      n++;
    end while (bvalid !== 1'b1 && n < 200);
    resp = bresp;
    bready <= 1'b0;
    @(posedge sys_clk);
    if (n >= 200) miscompares++;
  endtask

  task automatic axi_read(input logic [4:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (arready !== 1'b1 && n < 200);
    arvalid <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge sys_clk);
    if (n >= 200) miscompares++;
  endtask

  task automatic wait_level(input logic v);
    int n;
    n = 0;
    while (act !== v && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    check("active_flag", {31'h0, act}, {31'h0, v});
  endtask

  // Samples come back in channel order 0..2, since the range is 0 to 2.
  task automatic drain(input int cnt);
    for (int j = 0; j < cnt; j++) begin
      axi_read(`ASF_REG_DATA);
      check("sample", rd, {1'b1, 11'h0, ech, 16'hc3a0 + ech});
      check("data_rresp", {30'h0, resp}, {30'h0, `ASF_RESP_OKAY});
      ech = (ech == 4'h2) ? 4'h0 : ech + 4'h1;
    end
  endtask

  task automatic setup(input logic [5:0] ctrl);
    axi_write(`ASF_REG_CTRL, {26'h0, ctrl});
    axi_write(`ASF_REG_CHAN, 32'h0000_0020);
    check("chan_bresp", {30'h0, resp}, {30'h0, `ASF_RESP_OKAY});
    axi_write(`ASF_REG_CMD, 32'h0000_0006);
    ech = 4'h0;
  endtask

  // Source 0 is the software start, 1 the timer tick, 2 the pin.
  task automatic run_mode(input logic [5:0] ctrl, input int src,
    input int ntrig, input int per, input logic [31:0] cnt);
    setup(ctrl);
    for (int i = 0; i < ntrig; i++) begin
      check("irq_early", {31'h0, irq}, 32'h0);
      if (src == 0) begin
        axi_write(`ASF_REG_CMD, 32'h0000_0001);
      end else begin
        tick <= (src == 1);
        ext_pin <= (src == 2);
        @(posedge sys_clk);
        tick <= 1'b0;
        wait_level(1'b1);
        ext_pin <= 1'b0;
      end
      wait_level(1'b0);
      drain(per);
    end
    check("irq_final", {31'h0, irq}, {31'h0, ctrl[0]});
    axi_read(`ASF_REG_COUNT);
    check("count", rd, cnt);
    axi_write(`ASF_REG_CMD, 32'h0000_0002);
    check("irq_clear", {31'h0, irq}, 32'h0);
  endtask

  // --------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    #640000;
    miscompares++;
    complete_run();
  end

  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready, ext_pin, tick} = 0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0000_0000;
    miscompares = 0;
    comparisons = 0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    axi_read(`ASF_REG_CTRL);
    check("ctrl_reset", rd, 32'h0000_0000);
    axi_read(`ASF_REG_CHAN);
    check("chan_reset", rd, 32'h0000_00f0);
    axi_read(`ASF_REG_STATUS);
    check("status_reset", rd, 32'h0000_0002);
    axi_read(5'h18);
    check("unmapped_rd", rd, 32'h0000_0000);
    check("unmapped_rresp", {30'h0, resp}, {30'h0, `ASF_RESP_SLVERR});
    axi_write(5'h1c, 32'h0000_0001);
    check("unmapped_bresp", {30'h0, resp}, {30'h0, `ASF_RESP_SLVERR});
    setup(6'h31);
    axi_write(`ASF_REG_CMD, 32'h0000_0001);
    axi_read(`ASF_REG_CMD);
    check("sw_ignored", rd & 32'h0000_0001, 32'h0000_0000);
    run_mode(6'h02, 0, 4, 1, 32'd4);
    run_mode(6'h08, 0, 2, 3, 32'd6);
    run_mode(6'h31, 1, 1, 1, 32'd1);
    run_mode(6'h35, 1, 1, 1, 32'd1);
    run_mode(6'h11, 2, 1, 1, 32'd1);
    run_mode(6'h39, 1, 1, 3, 32'd3);
    run_mode(6'h3d, 1, 1, 3, 32'd3);
    run_mode(6'h37, 1, 256, 1, 32'd256);
    run_mode(6'h3f, 1, 86, 3, 32'd258);
    run_mode(6'h33, 1, 1024, 1, 32'd1024);
    run_mode(6'h3b, 1, 342, 3, 32'd1026);
    setup(6'h00);
    for (int k = 0; k < 17; k++) begin
      axi_write(`ASF_REG_CMD, 32'h0000_0001);
      if (k < 16) wait_level(1'b0);
    end
    axi_read(`ASF_REG_STATUS);
    check("fifo_full", rd & 32'h0000_1f06, 32'h0000_1004);
    axi_read(`ASF_REG_CMD);
    check("stall_active", rd & 32'h0000_0001, 32'h0000_0001);
    drain(17);
    wait_level(1'b0);
    axi_read(`ASF_REG_STATUS);
    check("fifo_empty", rd & 32'h0000_0006, 32'h0000_0002);
    complete_run();
  end
endmodule // adc_scan_fifo_irq_control_tb
